//--- design/ascs_pkg.sv
/*
 * Package of the serial control/status block: register offsets,
 * bit positions, reset values and the packed carriers.
 * Assumes a 32-bit APB with byte addresses and one register per word.
 */
package ascs_pkg;

    localparam int unsigned ADDR_W = 8;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL_B = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STAT_A = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_DATA = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CFG = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_EVT = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_MASK = 8'h14;

    // serial_control_b bit positions
    localparam int unsigned CB_TX_ON = 3;
    localparam int unsigned CB_RX_ON = 2;
    localparam int unsigned CB_STANDBY = 1;
    localparam int unsigned CB_BREAK = 0;

    // serial_status_a bit positions
    localparam int unsigned SA_TX_EMPTY = 7;
    localparam int unsigned SA_TX_DONE = 6;
    localparam int unsigned SA_RX_FULL = 5;

    // configuration bit positions
    localparam int unsigned CF_LOOP = 0;
    localparam int unsigned CF_WAKE = 1;
    localparam int unsigned CF_LONG_BRK = 2;

    // event bit positions, shared by event and mask registers
    localparam int unsigned EV_TX_EMPTY = 0;
    localparam int unsigned EV_TX_DONE = 1;
    localparam int unsigned EV_RX_FULL = 2;
    localparam int unsigned EV_WAKE = 3;
    localparam int unsigned EV_N = 4;

    // values after reset
    localparam logic [7:0] CTRL_B_RST = 8'h00;
    localparam logic [2:0] CFG_RST = 3'h0;
    localparam logic [EV_N-1:0] EVT_RST = 4'h0;
    localparam logic [EV_N-1:0] MASK_RST = 4'h0;
    localparam logic [7:0] DATA_RST = 8'h00;

    typedef enum logic {
        WAKE_IDLE_LINE,
        WAKE_ADDR_MARK
    } ascs_wake_type;

    typedef struct packed {
        logic tx_unit_on;
        logic rx_unit_on;
        logic receive_standby;
        logic break_request;
    } ascs_ctrl_type;

    typedef struct packed {
        logic long_break_select;
        ascs_wake_type wake_select;
        logic loop_select;
    } ascs_cfg_type;

    typedef struct packed {
        logic tx_buffer_empty;
        logic tx_all_done;
        logic rx_buffer_full;
    } ascs_flag_type;

    localparam ascs_ctrl_type CTRL_RST = '{1'b0, 1'b0, 1'b0, 1'b0};
    localparam ascs_flag_type FLAG_RST = '{1'b1, 1'b1, 1'b0};

endpackage

//--- design/ascs_ctrl.sv
/*
 * Control bits and first status flags of an asynchronous serial port,
 * reached over APB. Holds the transmit buffer and receive data register
 * and the arming logic for the read-status-then-access clear sequences.
 * Assumes the shifters, baud logic and wake detector run on clk_sys_i
 * and talk to this block through single-cycle strobes.
 */
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module ascs_ctrl
    import ascs_pkg::*;
(
    // clock, reset, freeze
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic ce_i,

    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,

    // transmit shifter side
    input wire logic tx_load_i,
    input wire logic tx_busy_i,
    input wire logic tx_pre_taken_i,
    input wire logic tx_brk_taken_i,
    output logic [7:0] tx_data_o,
    output logic tx_data_valid_o,
    output logic tx_preamble_req_o,
    output logic tx_break_req_o,
    output logic tx_long_break_o,
    output logic tx_pin_serial_o,

    // receive shifter and wake detector side
    input wire logic rx_char_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_msb_i,
    input wire logic rx_idle_i,
    output logic rx_pin_serial_o,
    output logic rx_standby_o,

    // interrupt
    output logic irq_o
);

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = hit(a, OFS_CTRL_B) | hit(a, OFS_STAT_A) | hit(a, OFS_DATA)
               | hit(a, OFS_CFG) | hit(a, OFS_EVT) | hit(a, OFS_MASK);
    endfunction

    // bus state
    logic ph_q, ph_d;
    logic [31:0] rdata_q, rdata_d;
    logic acc;
    logic wr;
    logic rd;

    // register state
    ascs_ctrl_type ctrl_q, ctrl_d;
    ascs_cfg_type cfg_q, cfg_d;
    ascs_flag_type flag_q, flag_d;
    ascs_flag_type arm_q, arm_d;
    logic [EV_N-1:0] evt_q, evt_d;
    logic [EV_N-1:0] mask_q, mask_d;
    logic [7:0] txbuf_q, txbuf_d;
    logic txfull_q, txfull_d;
    logic [7:0] rxbuf_q, rxbuf_d;
    logic pre_q, pre_d;
    logic brkq_q, brkq_d;

    // next-state helpers
    logic tx_rise;
    logic brk_wr1;
    logic data_wr;
    logic data_rd;
    logic wake;
    logic rx_take;
    logic [EV_N-1:0] ev_set;
    ascs_ctrl_type ctrl_wr;

    // one wait-free access phase after a captured setup cycle
    assign acc = psel_i & penable_i & ph_q & ce_i;
    assign wr = acc & pwrite_i;
    assign rd = acc & ~pwrite_i;
    assign pready_o = ph_q & ce_i;
    assign pslverr_o = pready_o & ~mapped(paddr_i);
    assign prdata_o = rdata_q;

    assign ctrl_wr = ascs_ctrl_type'(pwdata_i[3:0]);

    always_comb
    begin
        ph_d = ph_q;
        rdata_d = rdata_q;
        ctrl_d = ctrl_q;
        cfg_d = cfg_q;
        flag_d = flag_q;
        arm_d = arm_q;
        evt_d = evt_q;
        mask_d = mask_q;
        txbuf_d = txbuf_q;
        txfull_d = txfull_q;
        rxbuf_d = rxbuf_q;
        pre_d = pre_q;
        brkq_d = brkq_q;
        ev_set = '0;

        tx_rise = wr & hit(paddr_i, OFS_CTRL_B) & ctrl_wr.tx_unit_on & ~ctrl_q.tx_unit_on;
        brk_wr1 = wr & hit(paddr_i, OFS_CTRL_B) & ctrl_wr.break_request;
        data_wr = wr & hit(paddr_i, OFS_DATA);
        data_rd = rd & hit(paddr_i, OFS_DATA);

        // setup capture: read data is registered before the access phase
        if (psel_i & ~penable_i)
        begin
            ph_d = 1'b1;
            rdata_d = '0;
            if (!pwrite_i)
            begin
                if (hit(paddr_i, OFS_CTRL_B))
                    rdata_d[3:0] = ctrl_q;
                if (hit(paddr_i, OFS_STAT_A))
                begin
                    rdata_d[SA_TX_EMPTY] = flag_q.tx_buffer_empty;
                    rdata_d[SA_TX_DONE] = flag_q.tx_all_done;
                    rdata_d[SA_RX_FULL] = flag_q.rx_buffer_full;
                end
                if (hit(paddr_i, OFS_DATA))
                    rdata_d[7:0] = rxbuf_q;
                if (hit(paddr_i, OFS_CFG))
                    rdata_d[2:0] = cfg_q;
                if (hit(paddr_i, OFS_EVT))
                    rdata_d[EV_N-1:0] = evt_q;
                if (hit(paddr_i, OFS_MASK))
                    rdata_d[EV_N-1:0] = mask_q;
            end
        end
        else if (acc)
        begin
            ph_d = 1'b0;
        end

        if (cfg_q.wake_select == WAKE_IDLE_LINE)
            wake = ctrl_q.receive_standby & rx_idle_i;
        else
            wake = ctrl_q.receive_standby & rx_char_i & rx_msb_i;
        // non-waking characters are dropped in standby
        rx_take = rx_char_i & (~ctrl_q.receive_standby | wake);

        // control writes
        if (wr & hit(paddr_i, OFS_CTRL_B))
            ctrl_d = ctrl_wr;
        else if (wake)
            ctrl_d.receive_standby = 1'b0;
        // a standby write of one always lands, even against a wake
        if (wr & hit(paddr_i, OFS_CTRL_B) & ctrl_wr.receive_standby)
            ctrl_d.receive_standby = 1'b1;

        if (wr & hit(paddr_i, OFS_CFG))
            cfg_d = ascs_cfg_type'(pwdata_i[2:0]);
        if (wr & hit(paddr_i, OFS_MASK))
            mask_d = pwdata_i[EV_N-1:0];

        if (tx_rise)
            pre_d = 1'b1;
        else if (tx_pre_taken_i | ~ctrl_q.tx_unit_on)
            pre_d = 1'b0;

        // a one written to the break bit while it is clear queues one break
        if (brk_wr1 & ~ctrl_q.break_request)
            brkq_d = 1'b1;
        else if (tx_brk_taken_i)
            brkq_d = 1'b0;

        // transmit buffer occupancy
        if (data_wr)
        begin
            txbuf_d = pwdata_i[7:0];
            txfull_d = 1'b1;
        end
        else if (tx_load_i)
            txfull_d = 1'b0;

        // receive data register
        if (rx_take)
            rxbuf_d = rx_data_i;

        // status reads arm the clear sequences, writes do nothing
        if (rd & hit(paddr_i, OFS_STAT_A))
        begin
            arm_d.tx_buffer_empty = rdata_q[SA_TX_EMPTY];
            arm_d.tx_all_done = rdata_q[SA_TX_DONE];
            arm_d.rx_buffer_full = rdata_q[SA_RX_FULL];
        end

        if (data_wr & arm_q.tx_buffer_empty)
        begin
            flag_d.tx_buffer_empty = 1'b0;
            arm_d.tx_buffer_empty = 1'b0;
        end
        // buffer to shifter sets buffer-empty, set wins
        if (tx_load_i)
        begin
            flag_d.tx_buffer_empty = 1'b1;
            ev_set[EV_TX_EMPTY] = ~flag_q.tx_buffer_empty;
        end

        // armed write, enable rise or break write clears all-done
        if (arm_q.tx_all_done & (data_wr | tx_rise | brk_wr1))
        begin
            flag_d.tx_all_done = 1'b0;
            arm_d.tx_all_done = 1'b0;
        end
        // idle transmitter sets all-done
        // work queued in this very cycle must keep it clear, else the set beats every clear
        if (flag_q.tx_buffer_empty & ~txfull_q & ~tx_busy_i & ~pre_q & ~brkq_q
            & ~ctrl_q.break_request & ~tx_load_i
            & ~tx_rise & ~data_wr & ~brk_wr1)
        begin
            flag_d.tx_all_done = 1'b1;
            ev_set[EV_TX_DONE] = ~flag_q.tx_all_done;
        end

        if (data_rd & arm_q.rx_buffer_full)
        begin
            flag_d.rx_buffer_full = 1'b0;
            arm_d.rx_buffer_full = 1'b0;
        end
        // character into data register sets buffer-full, set wins
        if (rx_take)
        begin
            flag_d.rx_buffer_full = 1'b1;
            ev_set[EV_RX_FULL] = 1'b1;
        end

        ev_set[EV_WAKE] = wake;

        // sticky events, write one to clear, a new event wins
        for (int i = 0; i < EV_N; i++)
        begin
            if (wr & hit(paddr_i, OFS_EVT) & pwdata_i[i])
                evt_d[i] = 1'b0;
            if (ev_set[i])
                evt_d[i] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ph_q <= 1'b0;
            rdata_q <= '0;
            ctrl_q <= CTRL_RST;
            cfg_q <= ascs_cfg_type'(CFG_RST);
            flag_q <= FLAG_RST;
            arm_q <= '0;
            evt_q <= EVT_RST;
            mask_q <= MASK_RST;
            txbuf_q <= DATA_RST;
            txfull_q <= 1'b0;
            rxbuf_q <= DATA_RST;
            pre_q <= 1'b0;
            brkq_q <= 1'b0;
        end
        else if (ce_i)
        begin
            ph_q <= ph_d;
            rdata_q <= rdata_d;
            ctrl_q <= ctrl_d;
            cfg_q <= cfg_d;
            flag_q <= flag_d;
            arm_q <= arm_d;
            evt_q <= evt_d;
            mask_q <= mask_d;
            txbuf_q <= txbuf_d;
            txfull_q <= txfull_d;
            rxbuf_q <= rxbuf_d;
            pre_q <= pre_d;
            brkq_q <= brkq_d;
        end
    end

    assign tx_data_o = txbuf_q;
    // buffer is only offered while the transmitter is on
    assign tx_data_valid_o = txfull_q & ctrl_q.tx_unit_on;
    assign tx_preamble_req_o = pre_q;
    // break bit held high keeps breaks coming
    // queued break plus held bit may give a second one
    assign tx_break_req_o = (brkq_q | ctrl_q.break_request) & ctrl_q.tx_unit_on;
    assign tx_long_break_o = cfg_q.long_break_select;
    // pin stays with the transmitter until queued work drains
    assign tx_pin_serial_o = ctrl_q.tx_unit_on | tx_busy_i | pre_q | brkq_q;
    // loop mode frees the pin too
    assign rx_pin_serial_o = ctrl_q.rx_unit_on & ~cfg_q.loop_select;
    assign rx_standby_o = ctrl_q.receive_standby;
    assign irq_o = |(evt_q & mask_q);

endmodule

`default_nettype wire

//--- verif/ascs_properties.sv
/* port-level checks of ascs_ctrl, bound into it;
   assumes zero-wait apb writes land on the access edge */
`timescale 1ns/1ps
`default_nettype none
module ascs_properties
    import ascs_pkg::*;
(
    // clock, reset, apb
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic pready_o,
    // serial side
    input wire logic tx_pre_taken_i,
    input wire logic tx_preamble_req_o,
    input wire logic tx_break_req_o,
    input wire logic tx_long_break_o,
    input wire logic rx_char_i,
    input wire logic rx_msb_i,
    input wire logic rx_idle_i,
    input wire logic rx_pin_serial_o,
    input wire logic rx_standby_o
);
    logic wr_c;
    logic wr_f;
    logic [6:0] sh_q;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    assign wr_c = psel_i & penable_i & pwrite_i & pready_o & (paddr_i == OFS_CTRL_B);
    assign wr_f = psel_i & penable_i & pwrite_i & pready_o & (paddr_i == OFS_CFG);
    // shadow of software bits; standby bit is not used, hardware clears it
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
        if (!rst_n_i)
            sh_q <= 7'h00;
        else if (wr_c)
            sh_q[3:0] <= pwdata_i[3:0];
        else if (wr_f)
            sh_q[6:4] <= pwdata_i[2:0];
    rx_pin_own_a: assert property (rx_pin_serial_o == (sh_q[CB_RX_ON] & ~sh_q[4+CF_LOOP]))
        else $error("rx pin owner wrong");
    standby_set_a: assert property ($rose(rx_standby_o) |-> $past(wr_c && pwdata_i[CB_STANDBY]))
        else $error("standby set without write");
    idle_wake_a: assert property (rx_standby_o && rx_idle_i && !sh_q[4+CF_WAKE] && !wr_c |=> !rx_standby_o)
        else $error("idle did not wake");
    mark_wake_a: assert property (rx_standby_o && rx_char_i && rx_msb_i && sh_q[4+CF_WAKE] && !wr_c |=> !rx_standby_o)
        else $error("mark did not wake");
    break_hold_a: assert property (sh_q[CB_BREAK] && sh_q[CB_TX_ON] |-> tx_break_req_o)
        else $error("break request dropped");
    long_brk_a: assert property (tx_long_break_o == sh_q[4+CF_LONG_BRK])
        else $error("long break select wrong");
    pre_rise_a: assert property ($rose(tx_preamble_req_o) |-> $past(wr_c && pwdata_i[CB_TX_ON] && !sh_q[CB_TX_ON]))
        else $error("preamble without enable rise");
    pre_drop_a: assert property (tx_pre_taken_i |=> !tx_preamble_req_o)
        else $error("preamble kept after taken");
    cover property (rx_standby_o && rx_idle_i);
    cover property (tx_pre_taken_i);
    cover property (tx_break_req_o && tx_long_break_o);
endmodule
bind ascs_ctrl ascs_properties u_props (.clk_sys_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .pready_o, .tx_pre_taken_i, .tx_preamble_req_o, .tx_break_req_o,
    .tx_long_break_o, .rx_char_i, .rx_msb_i, .rx_idle_i, .rx_pin_serial_o, .rx_standby_o);
`default_nettype wire

//--- verif/ascs_shift_model.sv
/* model of the transmit shifter behind ascs_ctrl;
   assumes same clock, each unit busy for six cycles */
`timescale 1ns/1ps
`default_nettype none
module ascs_shift_model
(
    // clock, reset, pacing
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic stall_i,
    // requests, then strobes {preamble, break, load}
    input wire logic valid_i,
    input wire logic pre_i,
    input wire logic brk_i,
    output logic [2:0] take_o,
    output logic busy_o,
    output logic [7:0] brk_n_o
);
    logic [2:0] take_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    // busy while a unit is sent
    assign busy_o = cnt_q != 4'h0;
    always_comb
    begin
        take_d = 3'h0;
        if (!busy_o && !stall_i)
        begin
            if (pre_i)
                take_d = 3'h4;
            else if (brk_i)
                take_d = 3'h2;
            else if (valid_i)
                take_d = 3'h1;
        end
        cnt_d = (take_d != 3'h0) ? 4'h6 : cnt_q - 4'(busy_o);
    end
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            take_o <= 3'h0;
            cnt_q <= 4'h0;
            brk_n_o <= 8'h00;
        end
        else
        begin
            take_o <= take_d;
            cnt_q <= cnt_d;
            brk_n_o <= brk_n_o + 8'(take_d[1]);
        end
    end
endmodule
`default_nettype wire

//--- verif/tb.sv
/* bench of ascs_ctrl: apb master, row table, hand tests;
   assumes ascs_shift_model on the transmit side */
`timescale 1ns/1ps
`default_nettype none
module tb
    import ascs_pkg::*;
;
    logic clk_sys_i, rst_n_i, ce_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic [ADDR_W-1:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic tx_load_i, tx_busy_i, tx_pre_taken_i, tx_brk_taken_i, tx_data_valid_o;
    logic tx_preamble_req_o, tx_break_req_o, tx_long_break_o, rx_char_i, rx_msb_i;
    logic rx_idle_i, rx_pin_serial_o, rx_standby_o, irq_o, stall, err_s, ok, tx_pin;
    logic [7:0] tx_data_o, rx_data_i, brk_n, n0;
    int n_errors = 0;
    int comparisons = 0;
    logic [31:0] rst_v [6] = '{32'h0, 32'hC0, 32'h0, 32'h0, 32'h0, 32'h0};
    // address, write data, read back, {rx pin, slave error}
    logic [73:0] rows [8] = '{{OFS_CTRL_B, 32'h4, 32'h4, 2'b10},
        {OFS_CFG, 32'h1, 32'h1, 2'b00}, {OFS_CFG, 32'h6, 32'h6, 2'b10},
        {OFS_CTRL_B, 32'h0, 32'h0, 2'b00}, {OFS_STAT_A, 32'h0, 32'hC0, 2'b00},
        {OFS_MASK, 32'hF, 32'hF, 2'b00}, {OFS_MASK, 32'h0, 32'h0, 2'b00},
        {8'h18, 32'hF, 32'h0, 2'b01}};
    ascs_ctrl u_dut (.clk_sys_i, .rst_n_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .tx_load_i, .tx_busy_i, .tx_pre_taken_i,
        .tx_brk_taken_i, .tx_data_o, .tx_data_valid_o, .tx_preamble_req_o, .tx_break_req_o,
        .tx_long_break_o, .tx_pin_serial_o(tx_pin), .rx_char_i, .rx_data_i, .rx_msb_i, .rx_idle_i,
        .rx_pin_serial_o, .rx_standby_o, .irq_o);
    ascs_shift_model u_model (.clk_sys_i, .rst_n_i, .stall_i(stall), .valid_i(tx_data_valid_o),
        .pre_i(tx_preamble_req_o), .brk_i(tx_break_req_o), .busy_o(tx_busy_i), .brk_n_o(brk_n),
        .take_o({tx_pre_taken_i, tx_brk_taken_i, tx_load_i}));
    initial
    begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    task automatic end_sim;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e)
        begin
            n_errors++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // read data and error are taken at the edge where pready is high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_sys_i);
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        do
        begin
            @(posedge clk_sys_i);
            {ok, err_s, rd} = {pready_o === 1'b1, pslverr_o, prdata_o};
            n++;
        end
        while (!ok && n < 16);
        {psel_i, penable_i} <= 2'b00;
        chk({31'h0, ok}, 32'h1);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask
    // released data lines show the inverse of the last value
    task automatic rx_pulse(input logic c, input logic [7:0] d);
        @(posedge clk_sys_i);
        {rx_char_i, rx_idle_i, rx_msb_i, rx_data_i} <= {c, ~c, d[7], d};
        @(posedge clk_sys_i);
        {rx_char_i, rx_idle_i, rx_msb_i, rx_data_i} <= {2'b00, ~d[7], ~d};
        @(negedge clk_sys_i);
    endtask
    initial
    begin
        repeat (5000) @(posedge clk_sys_i);
        n_errors++;
        end_sim;
    end
    initial
    begin
        {psel_i, penable_i, pwrite_i, rx_char_i, rx_msb_i, rx_idle_i, rst_n_i} = 7'h00;
        {paddr_i, pwdata_i, rx_data_i} = 48'h0;
        {ce_i, stall} = 2'b11;
        repeat (5) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        foreach (rst_v[i])
            rc(8'(4 * i), '1, rst_v[i]);
        foreach (rows[i])
        begin
            apb(1'b1, rows[i][73:66], rows[i][65:34]);
            apb(1'b0, rows[i][73:66], 32'h0);
            chk(rd, rows[i][33:2]);
            chk({30'h0, rx_pin_serial_o, err_s}, {30'h0, rows[i][1:0]});
        end
        rc(OFS_STAT_A, 32'hC0, 32'hC0);
        apb(1'b1, OFS_CTRL_B, 32'h8);
        @(negedge clk_sys_i);
        chk({31'h0, tx_preamble_req_o}, 32'h1);
        chk({31'h0, tx_pin}, 32'h1);
        rc(OFS_STAT_A, 32'hC0, 32'h80);
        apb(1'b1, OFS_DATA, 32'h5A);
        rc(OFS_STAT_A, 32'hC0, 32'h0);
        chk({23'h0, tx_data_valid_o, tx_data_o}, 32'h15A);
        stall <= 1'b0;
        repeat (40) @(posedge clk_sys_i);
        rc(OFS_STAT_A, 32'hC0, 32'hC0);
        rc(OFS_EVT, '1, 32'h3);
        chk({31'h0, irq_o}, 32'h0); // masked
        apb(1'b1, OFS_MASK, 32'h2);
        @(negedge clk_sys_i);
        chk({31'h0, irq_o}, 32'h1); // raised
        apb(1'b1, OFS_EVT, 32'h3);
        @(negedge clk_sys_i);
        chk({31'h0, irq_o}, 32'h0); // cleared
        stall <= 1'b1;
        rc(OFS_STAT_A, 32'h40, 32'h40);
        apb(1'b1, OFS_CTRL_B, 32'h9);
        @(negedge clk_sys_i);
        chk({30'h0, tx_break_req_o, tx_long_break_o}, 32'h3);
        rc(OFS_STAT_A, 32'h40, 32'h0);
        n0 = brk_n;
        stall <= 1'b0;
        repeat (30) @(posedge clk_sys_i);
        apb(1'b1, OFS_CTRL_B, 32'h8);
        chk({31'h0, brk_n - n0 > 8'h02}, 32'h1);
        repeat (20) @(posedge clk_sys_i);
        n0 = brk_n;
        repeat (20) @(posedge clk_sys_i);
        chk({24'h0, brk_n}, {24'h0, n0});
        rc(OFS_STAT_A, 32'h40, 32'h40);
        apb(1'b1, OFS_CTRL_B, 32'h4);
        @(negedge clk_sys_i);
        chk({31'h0, tx_pin}, 32'h0); // pin released
        apb(1'b1, OFS_CFG, 32'h0);
        rx_pulse(1'b1, 8'hA5);
        rc(OFS_STAT_A, 32'h20, 32'h20);
        rc(OFS_DATA, '1, 32'hA5);
        rc(OFS_STAT_A, 32'h20, 32'h0);
        apb(1'b1, OFS_CTRL_B, 32'h6);
        rx_pulse(1'b1, 8'h91);
        chk({31'h0, rx_standby_o}, 32'h1);
        rc(OFS_STAT_A, 32'h20, 32'h0);
        rx_pulse(1'b0, 8'h00);
        chk({31'h0, rx_standby_o}, 32'h0);
        apb(1'b1, OFS_CFG, 32'h2);
        apb(1'b1, OFS_CTRL_B, 32'h6);
        rx_pulse(1'b1, 8'h22);
        rc(OFS_STAT_A, 32'h20, 32'h0);
        rx_pulse(1'b1, 8'h93);
        chk({31'h0, rx_standby_o}, 32'h0);
        rc(OFS_DATA, '1, 32'h93);
        end_sim;
    end
endmodule
`default_nettype wire
